//--- core/tcp_pkg.sv
package tcp_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int           TCP_NCH        = 4;
	localparam logic [7:0]   TCP_ADR_CTRL   = 8'h00;
	localparam logic [7:0]   TCP_ADR_DIV    = 8'h04;
	localparam logic [7:0]   TCP_ADR_PERIOD = 8'h08;
	localparam logic [7:0]   TCP_ADR_CMP    = 8'h0c;
	localparam logic [7:0]   TCP_ADR_DEAD   = 8'h10;
	localparam logic [7:0]   TCP_ADR_COUNT  = 8'h14;
	localparam logic [7:0]   TCP_ADR_CAPT   = 8'h18;
	localparam logic [7:0]   TCP_ADR_STAT   = 8'h1c;
	localparam logic [7:0]   TCP_ADR_MASK   = 8'h20;
	localparam logic [7:0]   TCP_CH_STRIDE  = 8'h40;
	// ctrl bit positions
	localparam int           TCP_CTL_EN     = 0;
	localparam int           TCP_CTL_ONESHOT = 1;
	localparam int           TCP_CTL_KILLT  = 2;
	localparam int           TCP_CTL_KILLC  = 3;
	localparam int           TCP_CTL_CAPEN  = 4;
	localparam int           TCP_CTL_W      = 5;
	// status bits
	localparam int           TCP_ST_TC      = 0;
	localparam int           TCP_ST_CC      = 1;
	localparam int           TCP_ST_CAP     = 2;
	localparam int           TCP_ST_KILL    = 3;
	localparam int           TCP_ST_W       = 4;
	// reset values
	localparam logic [15:0]  TCP_RST_PERIOD = 16'hffff;
	localparam logic [15:0]  TCP_RST_CMP    = 16'h0000;
	localparam logic [15:0]  TCP_RST_DIV    = 16'h0000;
	localparam logic [7:0]   TCP_RST_DEAD   = 8'h00;
endpackage : tcp_pkg

//--- core/tcp_chan.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_chan
	import tcp_pkg::*;
#(
	parameter int CW = 16,
	parameter int DW = 8
) (
	// clock, reset
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	// configuration
	input  wire logic [TCP_CTL_W-1:0] ctrl_i,
	input  wire logic [15:0]   div_i,
	input  wire logic [CW-1:0] period_i,
	input  wire logic [CW-1:0] cmp_i,
	input  wire logic [DW-1:0] dead_i,
	// pins
	input  wire logic          capture_i,
	input  wire logic          kill_i,
	output logic               line_o,
	output logic               line_compl_o,
	// state and events
	output logic [CW-1:0]      count_o,
	output logic [CW-1:0]      capt_o,
	output logic [TCP_ST_W-1:0] evt_o
);
	// widths the counter and dead-band logic can serve
	if (CW < 2 || CW > 32 || DW < 1 || DW > 16) begin : g_bad_width
		$error("tcp_chan: bad width");
	end

	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	logic [15:0]   div_ff;
	logic [CW-1:0] cnt_ff;
	logic          run_ff;
	logic [CW-1:0] capt_ff;
	logic          pwm_ff;
	logic          cap_d_ff;
	logic [DW-1:0] dt_ff;
	logic          line_ff;
	logic          compl_ff;
	logic [TCP_ST_W-1:0] evt_ff;

	wire en        = ctrl_i[TCP_CTL_EN];
	wire tick      = en && run_ff && (div_ff == div_i);
	wire at_period = (cnt_ff == period_i);
	wire cap_edge  = ctrl_i[TCP_CTL_CAPEN] && capture_i && !cap_d_ff;
	wire pwm_nxt   = en && (cnt_ff < cmp_i);
	wire pwm_chg   = (pwm_nxt != pwm_ff);
	wire dt_zero   = (dt_ff == '0);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_ff   <= TCP_RST_DIV;
			cnt_ff   <= '0;
			run_ff   <= 1'b0;
			capt_ff  <= '0;
			cap_d_ff <= 1'b0;
			pwm_ff   <= 1'b0;
			dt_ff    <= '0;
			line_ff  <= 1'b0;
			compl_ff <= 1'b0;
			evt_ff   <= '0;
		end else if (ce_i) begin
			cap_d_ff <= capture_i;
			evt_ff   <= '0;
			if (!en) begin
				// disabled: hold zero and rearm
				div_ff <= TCP_RST_DIV;
				cnt_ff <= '0;
				run_ff <= 1'b1;
			end else if (tick) begin
				div_ff <= TCP_RST_DIV;
				if (at_period) begin
					evt_ff[TCP_ST_TC] <= 1'b1;
					cnt_ff <= '0;
					run_ff <= !ctrl_i[TCP_CTL_ONESHOT];
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
				if (cnt_ff == cmp_i)
					evt_ff[TCP_ST_CC] <= 1'b1;
			end else if (run_ff) begin
				div_ff <= div_ff + 16'h0001;
			end
			if (cap_edge) begin
				capt_ff <= cnt_ff;
				evt_ff[TCP_ST_CAP] <= 1'b1;
			end
			if (kill_i)
				evt_ff[TCP_ST_KILL] <= 1'b1;
			// dead band: both low while the delay runs after a change
			pwm_ff <= pwm_nxt;
			if (pwm_chg) begin
				dt_ff    <= dead_i;
				line_ff  <= (dead_i == '0) && pwm_nxt;
				compl_ff <= (dead_i == '0) && !pwm_nxt && en;
			end else if (!dt_zero) begin
				dt_ff <= dt_ff - 1'b1;
				if (dt_ff == {{(DW-1){1'b0}}, 1'b1}) begin
					line_ff  <= pwm_ff;
					compl_ff <= !pwm_ff && en;
				end
			end else begin
				line_ff  <= pwm_ff;
				compl_ff <= !pwm_ff && en;
			end
		end
	end

	// ----------------------------------------------------------------
	// kill override is combinational so it acts at once
	// ----------------------------------------------------------------
	assign line_o       = kill_i ? ctrl_i[TCP_CTL_KILLT] : line_ff;
	assign line_compl_o = kill_i ? ctrl_i[TCP_CTL_KILLC] : compl_ff;
	assign count_o      = cnt_ff;
	assign capt_o       = capt_ff;
	assign evt_o        = evt_ff;
endmodule : tcp_chan
`default_nettype wire

//--- core/tcp_top.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - sixteen-bit counter, software-set period
// - capture event stores count, software readable
// - at period: halt or reload per configuration
// - compare against count yields pwm duty
// - true and complement outputs with dead band
// - kill forces outputs to preset state immediately
// - four independent timer units
// - count clock from sixteen-bit system clock divider
module tcp_top
	import tcp_pkg::*;
#(
	parameter int NCH = TCP_NCH
) (
	// clock, reset, enable
	input  wire logic           mclk_i,
	input  wire logic           rst_i,
	input  wire logic           ce_i,
	// register port
	input  wire logic [7:0]     addr_i,
	input  wire logic [31:0]    wdata_i,
	input  wire logic           wr_i,
	input  wire logic           rd_i,
	output logic [31:0]         rdata_o,
	// pins
	input  wire logic [NCH-1:0] capture_i,
	input  wire logic [NCH-1:0] kill_i,
	output logic [NCH-1:0]      line_o,
	output logic [NCH-1:0]      line_compl_o,
	// interrupt
	output logic                irq_o
);
	// two address bits select the channel
	if (NCH < 1 || NCH > 4) begin : g_bad_nch
		$error("tcp_top: NCH must be 1..4");
	end

	// ----------------------------------------------------------------
	// per-channel registers
	// ----------------------------------------------------------------
	logic [TCP_CTL_W-1:0] ctrl_ff  [NCH];
	logic [15:0]          div_ff   [NCH];
	logic [15:0]          per_ff   [NCH];
	logic [15:0]          cmp_ff   [NCH];
	logic [7:0]           dead_ff  [NCH];
	logic [TCP_ST_W-1:0]  stat_ff  [NCH];
	logic [TCP_ST_W-1:0]  mask_ff  [NCH];
	logic [31:0]          rdata_ff;
	logic [15:0]          count_w  [NCH];
	logic [15:0]          capt_w   [NCH];
	logic [TCP_ST_W-1:0]  evt_w    [NCH];
	logic [NCH-1:0]       irq_w;

	wire [1:0] sel_ch = addr_i[7:6];
	wire [7:0] sel_rg = {2'b00, addr_i[5:0]};
	wire       ch_ok  = ({30'h0, sel_ch} < NCH);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			wire wsel = wr_i && ch_ok && (sel_ch == 2'(g));
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					ctrl_ff[g] <= '0;
					div_ff[g]  <= TCP_RST_DIV;
					per_ff[g]  <= TCP_RST_PERIOD;
					cmp_ff[g]  <= TCP_RST_CMP;
					dead_ff[g] <= TCP_RST_DEAD;
					stat_ff[g] <= '0;
					mask_ff[g] <= '0;
				end else if (ce_i) begin
					if (wsel && sel_rg == TCP_ADR_CTRL)
						ctrl_ff[g] <= wdata_i[TCP_CTL_W-1:0];
					if (wsel && sel_rg == TCP_ADR_DIV)
						div_ff[g] <= wdata_i[15:0];
					if (wsel && sel_rg == TCP_ADR_PERIOD)
						per_ff[g] <= wdata_i[15:0];
					if (wsel && sel_rg == TCP_ADR_CMP)
						cmp_ff[g] <= wdata_i[15:0];
					if (wsel && sel_rg == TCP_ADR_DEAD)
						dead_ff[g] <= wdata_i[7:0];
					if (wsel && sel_rg == TCP_ADR_MASK)
						mask_ff[g] <= wdata_i[TCP_ST_W-1:0];
					// set wins over write-one-to-clear
					if (wsel && sel_rg == TCP_ADR_STAT)
						stat_ff[g] <= (stat_ff[g] & ~wdata_i[TCP_ST_W-1:0]) | evt_w[g];
					else
						stat_ff[g] <= stat_ff[g] | evt_w[g];
				end
			end

			tcp_chan #(
				.CW(16),
				.DW(8)
			) u_chan (
				.mclk_i       (mclk_i),
				.rst_i        (rst_i),
				.ce_i         (ce_i),
				.ctrl_i       (ctrl_ff[g]),
				.div_i        (div_ff[g]),
				.period_i     (per_ff[g]),
				.cmp_i        (cmp_ff[g]),
				.dead_i       (dead_ff[g]),
				.capture_i    (capture_i[g]),
				.kill_i       (kill_i[g]),
				.line_o       (line_o[g]),
				.line_compl_o (line_compl_o[g]),
				.count_o      (count_w[g]),
				.capt_o       (capt_w[g]),
				.evt_o        (evt_w[g])
			);

			assign irq_w[g] = |(stat_ff[g] & mask_ff[g]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (ch_ok) begin
			case (sel_rg)
				TCP_ADR_CTRL:   rmux = {27'h0, ctrl_ff[sel_ch]};
				TCP_ADR_DIV:    rmux = {16'h0, div_ff[sel_ch]};
				TCP_ADR_PERIOD: rmux = {16'h0, per_ff[sel_ch]};
				TCP_ADR_CMP:    rmux = {16'h0, cmp_ff[sel_ch]};
				TCP_ADR_DEAD:   rmux = {24'h0, dead_ff[sel_ch]};
				TCP_ADR_COUNT:  rmux = {16'h0, count_w[sel_ch]};
				TCP_ADR_CAPT:   rmux = {16'h0, capt_w[sel_ch]};
				TCP_ADR_STAT:   rmux = {28'h0, stat_ff[sel_ch]};
				TCP_ADR_MASK:   rmux = {28'h0, mask_ff[sel_ch]};
				default:        rmux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			rdata_ff <= 32'h0000_0000;
		else if (ce_i)
			rdata_ff <= rd_i ? rmux : 32'h0000_0000;
	end

	assign rdata_o = rdata_ff;
	assign irq_o   = |irq_w;
endmodule : tcp_top
`default_nettype wire

//--- test/tcp_switch.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_switch #(parameter int N = 4) (
	// gate drives
	input  wire logic [N-1:0] hi_i,
	input  wire logic [N-1:0] lo_i,
	input  wire logic         clk_i,
	// fault
	output logic              short_o
);
	// ------
	// half bridges
	// ------
	// both switches of a leg on shorts the supply; latched for the bench
	initial short_o = 1'b0;
	always @(posedge clk_i) if ((hi_i & lo_i) != '0) short_o <= 1'b1;
endmodule : tcp_switch
`default_nettype wire

//--- test/tcp_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module tcp_asserts
	import tcp_pkg::*;
#(parameter int NCH = TCP_NCH) (
	// clock, bus
	input wire logic           mclk_i,
	input wire logic           rst_i,
	input wire logic           ce_i,
	input wire logic [7:0]     addr_i,
	input wire logic [31:0]    wdata_i,
	input wire logic           wr_i,
	input wire logic           rd_i,
	input wire logic [31:0]    rdata_o,
	// pins
	input wire logic [NCH-1:0] capture_i,
	input wire logic [NCH-1:0] kill_i,
	input wire logic [NCH-1:0] line_o,
	input wire logic [NCH-1:0] line_compl_o,
	input wire logic           irq_o
);
	// ------
	// port relations
	// ------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// kill overrides the pins, so pwm relations hold on live legs only
	wire logic [NCH-1:0] live = ~kill_i;
	property p_rdz; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
	a_rdz: assert property (p_rdz)
		else $error("rdata not idle");
	property p_unm; rd_i && addr_i[5:0] > 6'h20 |=> rdata_o == 32'h0; endproperty
	a_unm: assert property (p_unm)
		else $error("unmapped read not zero");
	property p_cer; rd_i && !ce_i |=> rdata_o == 32'h0; endproperty
	a_cer: assert property (p_cer)
		else $error("read taken without enable");
	property p_ovl; ((line_o & line_compl_o) & live) == '0; endproperty
	a_ovl: assert property (p_ovl)
		else $error("both legs on");
	property p_kil; !$past(wr_i) |-> (({line_o, line_compl_o} ^ $past({line_o, line_compl_o}))
		& {2{kill_i & $past(kill_i)}}) == '0; endproperty
	a_kil: assert property (p_kil)
		else $error("killed leg moved");
	property p_frz; !$past(ce_i) && (kill_i | $past(kill_i)) == '0
		|-> $stable(line_o) && $stable(line_compl_o); endproperty
	a_frz: assert property (p_frz)
		else $error("outputs moved without enable");
	property p_rsi; $fell(rst_i) |-> !irq_o; endproperty
	a_rsi: assert property (p_rsi)
		else $error("irq after reset");
	property p_rsl; $fell(rst_i) |-> (((line_o | line_compl_o) & live) == '0) [*2]; endproperty
	a_rsl: assert property (p_rsl)
		else $error("outputs active after reset");
	c_irq: cover property ($rose(irq_o));
	c_kil: cover property (kill_i != '0);
	c_pwm: cover property ($rose(line_o[0]));
endmodule : tcp_asserts
bind tcp_top tcp_asserts #(.NCH(NCH)) chk_u (.mclk_i, .rst_i, .ce_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .capture_i, .kill_i, .line_o, .line_compl_o, .irq_o);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import tcp_pkg::*;
	// ------
	// stimulus and checks
	// ------
	logic        mclk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, irq_o, short;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = '0, rdata_o, rd_v;
	logic [3:0]  capture_i = '0, kill_i = '0, line_o, line_compl_o;
	int          n_fail = 0, n_compared = 0, seed = 65, cyc = 0, c, d, p, m, z, hi, lo;
	always #2.5 mclk_i = ~mclk_i;
	tcp_top dut_u (.mclk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.capture_i, .kill_i, .line_o, .line_compl_o, .irq_o);
	tcp_switch sw_u (.clk_i(mclk_i), .hi_i(line_o), .lo_i(line_compl_o), .short_o(short));
	function automatic logic [7:0] ra(input int ch, input logic [7:0] o);
		return {ch[1:0], o[5:0]};
	endfunction : ra
	// dead band eats the start of every on phase
	function automatic int on_t(input int n, input int dv, input int dz);
		return n * (dv + 1) - dz;
	endfunction : on_t
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= w;
		rd_i <= !w;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1 rd_v = rdata_o;
	endtask : bus
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (c = 0; c < 36; c++) begin
			bus(0, ra(c / 9, 8'(c % 9 * 4)), 0);
			chk(rd_v, 8'(c % 9 * 4) == TCP_ADR_PERIOD ? 32'hffff : 0, "reset");
		end
		bus(0, 8'h3c, 0);
		chk(rd_v, 0, "unmapped");
		for (c = 0; c < 4; c++) begin
			d = {$random(seed)} % 3;
			p = 6 + {$random(seed)} % 7;
			m = 2 + {$random(seed)} % (p - 2);
			// dead band kept shorter than the shortest phase
			z = {$random(seed)} % (2 * d + 2);
			bus(1, ra(c, TCP_ADR_DIV), d);
			bus(1, ra(c, TCP_ADR_PERIOD), p);
			bus(1, ra(c, TCP_ADR_CMP), m);
			bus(1, ra(c, TCP_ADR_DEAD), z);
			bus(1, ra(c, TCP_ADR_CTRL), 1);
			repeat (3 * (p + 1) * (d + 1)) @(posedge mclk_i);
			hi = 0;
			lo = 0;
			repeat ((p + 1) * (d + 1)) begin
				@(posedge mclk_i);
				#1 hi += line_o[c];
				lo += line_compl_o[c];
			end
			chk(hi, on_t(m, d, z), "on time");
			chk(lo, on_t(p + 1 - m, d, z), "off time");
		end
		#1 chk(irq_o, 0, "masked irq");
		bus(1, ra(0, TCP_ADR_MASK), 1);
		#1 chk(irq_o, 1, "irq");
		bus(1, ra(0, TCP_ADR_CTRL), 0);
		bus(1, ra(0, TCP_ADR_STAT), 32'hf);
		bus(0, ra(0, TCP_ADR_STAT), 0);
		chk(rd_v, 0, "stat clear");
		chk(irq_o, 0, "irq clear");
		bus(1, ra(0, TCP_ADR_CTRL), 3);
		repeat (100) @(posedge mclk_i);
		bus(0, ra(0, TCP_ADR_STAT), 0);
		chk(rd_v[0], 1, "wrap flag");
		for (c = 0; c < 3; c++) begin
			repeat (5) @(posedge mclk_i);
			bus(0, ra(0, TCP_ADR_COUNT), 0);
			chk(rd_v, 0, "halted");
		end
		bus(1, ra(1, TCP_ADR_CTRL), 32'h11);
		for (c = 0; c < 2; c++) begin
			repeat ({$random(seed)} % 5) @(posedge mclk_i);
			fork
				bus(0, ra(1, TCP_ADR_COUNT), 0);
				@(posedge mclk_i) capture_i <= 4'h2;
			join
			hi = rd_v;
			@(posedge mclk_i) capture_i <= 4'h0;
			bus(0, ra(1, TCP_ADR_CAPT), 0);
			chk(rd_v, hi, "capture");
		end
		bus(0, ra(1, TCP_ADR_STAT), 0);
		chk(rd_v[2], 1, "capture flag");
		for (c = 0; c < 3; c++) begin
			bus(1, ra(2, TCP_ADR_CTRL), 1 | c << 2);
			@(posedge mclk_i) kill_i <= 4'h4;
			#1 chk({line_compl_o[2], line_o[2]}, c, "kill");
			repeat (3) @(posedge mclk_i);
			kill_i <= 4'h0;
		end
		bus(0, ra(2, TCP_ADR_STAT), 0);
		chk(rd_v[3], 1, "kill flag");
		@(posedge mclk_i) ce_i <= 1'b0;
		bus(0, ra(3, TCP_ADR_PERIOD), 0);
		chk(rd_v, 0, "frozen read");
		@(posedge mclk_i) ce_i <= 1'b1;
		chk(short, 0, "shoot through");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
